// ==== testbench/motor_drivers.sv ====
`timescale 1ns/10ps
module motor_drivers
   import pwm_mgr_pkg::*;
(
   // Clock
   input  wire logic                         pclk,
   // From the channel pins
   input  wire logic [pwm_mgr_pkg::NCH-1:0]  pins,
   input  wire logic [pwm_mgr_pkg::NCH-1:0]  oe,
   input  wire logic [pwm_mgr_pkg::NCH-1:0]  pol,
   // Commands from the bench
   input  wire logic                         trip,
   input  wire logic                         fault,
   // Back to the controller
   output logic                              current_sense_input,
   output logic                              emergency_n,
   output logic [pwm_mgr_pkg::NCH-1:0]       switch_on
);
   logic [NCH-1:0] last;
   logic [NCH-1:0] level;
   // Released pins show the inverse of their last driven level
   assign level = (pins & oe) | (~last & ~oe);
   always_ff @(posedge pclk)
      last <= (pins & oe) | (last & ~oe);
   assign switch_on = oe & ~(level ^ pol);
   assign current_sense_input = trip;
   assign emergency_n = ~fault;
endmodule

// ==== testbench/motor_pwm_channel_manager_bench.sv ====
`timescale 1ns/10ps
module motor_pwm_channel_manager_bench;
   import pwm_mgr_pkg::*;
   logic           pclk = 1'b0;
   logic           presetn = 1'b0;
   logic           psel = 1'b0;
   logic           penable = 1'b0;
   logic           pwrite = 1'b0;
   logic [7:0]     paddr = 8'h0;
   logic [31:0]    pwdata = 32'h0;
   logic           pready, pslverr, current_sense_input, emergency_n;
   logic [31:0]    prdata;
   logic           timer_a_pwm = 1'b0;
   logic           commutation_event = 1'b0;
   logic           ratio_up_hw = 1'b0;
   logic           ratio_down_hw = 1'b0;
   logic           trip = 1'b0;
   logic           fault = 1'b0;
   logic           zero_cross_sample, e;
   logic [NCH-1:0] motor_channel_out, motor_channel_oe, switch_on;
   logic [NCH-1:0] pol = 6'h0;
   logic [31:0]    v;
   int             miscompares = 0;
   int             tests_run = 0;
   always #5 pclk = ~pclk;
   motor_pwm_channel_manager dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .timer_a_pwm(timer_a_pwm),
      .current_sense_input(current_sense_input),
      .commutation_event(commutation_event), .emergency_n(emergency_n),
      .ratio_up_hw(ratio_up_hw), .ratio_down_hw(ratio_down_hw),
      .motor_channel_out(motor_channel_out),
      .motor_channel_oe(motor_channel_oe),
      .zero_cross_sample(zero_cross_sample));
   motor_drivers drv (.pclk(pclk), .pins(motor_channel_out),
      .oe(motor_channel_oe), .pol(pol), .trip(trip), .fault(fault),
      .current_sense_input(current_sense_input),
      .emergency_n(emergency_n), .switch_on(switch_on));
   task automatic final_report;
      $display("compares %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   task automatic give_up;
      miscompares++;
      final_report;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      v = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
         give_up;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   function automatic logic [31:0] near(int a, int b);
      return (a - b <= 2 && b - a <= 2) ? 32'h1 : 32'h0;
   endfunction
   task automatic t_access;
      rd(OFF_CTRL_A);
      check(v, 32'h0);
      wr(OFF_ZPREV, 32'h5a);
      wr(OFF_RATIO, 32'h3);
      rd(OFF_ZPREV);
      check(v, 32'h5a);
      wr(OFF_CTRL_A, 32'h2);
      wr(OFF_ZCUR, 32'ha5);
      rd(OFF_ZCUR);
      check(v, 32'ha5);
      wr(OFF_CTRL_A, 32'h1);
      wr(OFF_ZPREV, 32'h11);
      rd(OFF_ZPREV);
      check(v, 32'h5a);
      wr(OFF_COMPARE, 32'h3c);
      rd(OFF_COMPARE);
      check(v, 32'h3c);
      wr(OFF_STATUS, 32'h2);
      wr(OFF_STATUS, 32'h0);
      rd(OFF_RATIO);
      check(v, 32'h4);
      wr(OFF_STATUS, 32'h1);
      rd(OFF_RATIO);
      check(v, 32'h3);
      wr(OFF_CTRL_A, 32'h3);
      wr(OFF_COMPARE, 32'h77);
      wr(OFF_DEMAG, 32'h42);
      rd(OFF_COMPARE);
      check(v, 32'h3c);
      rd(OFF_DEMAG);
      check(v, 32'h42);
      ratio_up_hw <= 1'b1;
      repeat (2) @(posedge pclk);
      ratio_up_hw <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(OFF_STATUS);
      check(v & 32'h3, 32'h2);
      rd(OFF_RATIO);
      check(v, 32'h4);
      wr(OFF_STATUS, 32'h0);
      ratio_down_hw <= 1'b1;
      repeat (2) @(posedge pclk);
      ratio_down_hw <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(OFF_STATUS);
      check(v & 32'h3, 32'h1);
      rd(8'h40);
      check({31'h0, e}, 32'h1);
      $display("done: register access");
   endtask
   task automatic t_channels;
      int n;
      wr(OFF_CTRL_B, 32'h0);
      wr(OFF_POLARITY, 32'h2a);
      pol <= 6'h2a;
      wr(OFF_PHASE, 32'h33);
      wr(OFF_CTRL_A, 32'h9);
      repeat (8) @(posedge pclk);
      check({26'h0, motor_channel_out}, 32'h26);
      check({26'h0, motor_channel_oe}, 32'h3f);
      check({26'h0, switch_on}, 32'h33);
      wr(OFF_CTRL_A, 32'h1);
      wr(OFF_PHASE, 32'h07);
      repeat (10) @(posedge pclk);
      check({26'h0, motor_channel_out}, 32'h26);
      commutation_event <= 1'b1;
      repeat (3) @(posedge pclk);
      commutation_event <= 1'b0;
      n = 0;
      while (motor_channel_out !== 6'h12 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20) give_up;
      check({26'h0, motor_channel_out}, 32'h12);
      check({26'h0, switch_on}, 32'h07);
      fault <= 1'b1;
      #2;
      check({26'h0, motor_channel_oe}, 32'h0);
      @(posedge pclk);
      fault <= 1'b0;
      rd(OFF_CTRL_A);
      check(v & 32'h1, 32'h0);
      $display("done: channel manager");
   endtask
   task automatic t_pwm;
      int n, w;
      wr(OFF_CTRL_A, 32'h1);
      timer_a_pwm <= 1'b1;
      trip <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(OFF_PWMSTAT);
      check(v & 32'h60, 32'h20);
      trip <= 1'b1;
      repeat (8) @(posedge pclk);
      rd(OFF_PWMSTAT);
      check(v & 32'h60, 32'h40);
      wr(OFF_CTRL_B, 32'h4);
      repeat (4) @(posedge pclk);
      check({26'h0, motor_channel_out}, 32'h12);
      wr(OFF_CTRL_B, 32'h2);
      repeat (4) @(posedge pclk);
      check({26'h0, motor_channel_out}, 32'h15);
      wr(OFF_CTRL_A, 32'h5);
      repeat (8) @(posedge pclk);
      rd(OFF_PWMSTAT);
      check(v & 32'h20, 32'h0);
      wr(OFF_CTRL_B, 32'h3);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         while (motor_channel_out !== 6'h12 && n < 9000) begin
            @(posedge pclk);
            n++;
         end
         w = 0;
         while (motor_channel_out === 6'h12 && w < 500) begin
            @(posedge pclk);
            w++;
         end
      end
      if (n >= 9000) give_up;
      check(near(w, BLANK_CYC), 32'h1);
      trip <= 1'b0;
      $display("done: pwm source");
   endtask
   task automatic meas(output int hi, output int per);
      int n;
      n = 0;
      while (zero_cross_sample === 1'b1 && n < 9000) begin
         @(posedge pclk);
         n++;
      end
      while (zero_cross_sample !== 1'b1 && n < 18000) begin
         @(posedge pclk);
         n++;
      end
      hi = 0;
      while (zero_cross_sample === 1'b1 && hi < 9000) begin
         @(posedge pclk);
         hi++;
      end
      per = hi;
      while (zero_cross_sample !== 1'b1 && per < 9000) begin
         @(posedge pclk);
         per++;
      end
      if (per >= 9000 || n >= 18000)
         give_up;
   endtask
   task automatic t_window;
      int hi, per, cnt;
      timer_a_pwm <= 1'b0;
      wr(OFF_CTRL_A, 32'h1);
      wr(OFF_PRESCALE, 32'h0);
      for (int k = 0; k < 4; k++) begin
         wr(OFF_POLARITY, {22'h0, k[1:0], 8'h2a});
         meas(hi, per);
         meas(hi, per);
         check(near(hi, OFF_US[k] * CLK_MHZ), 32'h1);
         check(near(per, WIN_NS[0] * CLK_MHZ / 1000), 32'h1);
      end
      wr(OFF_CTRL_A, 32'h11);
      wr(OFF_PRESCALE, 32'h1);
      meas(hi, per);
      meas(hi, per);
      check(near(hi, OT_SENSOR_CYC), 32'h1);
      check(near(per, WIN_NS[1] * CLK_MHZ / 1000), 32'h1);
      timer_a_pwm <= 1'b1;
      repeat (8) @(posedge pclk);
      cnt = 0;
      repeat (6000) begin
         @(posedge pclk);
         if (zero_cross_sample !== 1'b0)
            cnt++;
      end
      check(cnt, 0);
      $display("done: measurement window");
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_access;
      t_channels;
      t_pwm;
      t_window;
      final_report;
   end
endmodule

// ==== testbench/motor_pwm_chk.sv ====
`timescale 1ns/10ps
module motor_pwm_chk
   import pwm_mgr_pkg::*;
(
   // Clock and reset
   input wire logic                         pclk,
   input wire logic                         presetn,
   // APB
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic [7:0]                   paddr,
   input wire logic                         pready,
   input wire logic                         pslverr,
   input wire logic [31:0]                  prdata,
   // Motor side
   input wire logic                         emergency_n,
   input wire logic [pwm_mgr_pkg::NCH-1:0]  motor_channel_oe,
   input wire logic                         zero_cross_sample
);
   localparam int ZC_MAX = OFF_US[3] * CLK_MHZ + 2;
   logic [15:0] zc_cnt;
   logic [15:0] next_zc_cnt;
   // Length of the current sampling pulse
   always_comb begin
      next_zc_cnt = zero_cross_sample ? zc_cnt + 16'h1 : 16'h0;
      if (zc_cnt == 16'hffff)
         next_zc_cnt = zc_cnt;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         zc_cnt <= 16'h0;
      else
         zc_cnt <= next_zc_cnt;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup:
      assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_single:
      assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_with_ready:
      assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_quiet:
      assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero outside answer");
   a_unmapped_err:
      assert property (psel && !penable && paddr > OFF_PWMSTAT
         |=> pready && pslverr)
      else $error("unmapped access not refused");
   a_mapped_ok:
      assert property (psel && !penable && paddr <= OFF_PWMSTAT &&
         paddr[1:0] == 2'b00 |=> !pslverr)
      else $error("mapped access refused");
   a_estop_hiz:
      assert property (!emergency_n |-> motor_channel_oe == '0)
      else $error("outputs driven during emergency");
   a_estop_stays_off:
      assert property ($rose(emergency_n) |-> (motor_channel_oe == '0)[*2])
      else $error("outputs back on after emergency");
   a_zc_width_max:
      assert property (zc_cnt <= ZC_MAX)
      else $error("sampling pulse too long");
endmodule

bind motor_pwm_channel_manager motor_pwm_chk chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .emergency_n(emergency_n), .motor_channel_oe(motor_channel_oe),
   .zero_cross_sample(zero_cross_sample)
);

// ==== verilog/motor_pwm_channel_manager.sv ====
`timescale 1ns/10ps
// Operation
// - Config and e-stop modes allow full access
// - Switched: timers read-only, flags step ratio
// - Auto: demag and flags writable only
// - Voltage mode uses external timer PWM
// - Comparator trip cuts voltage-mode PWM
// - Zero crossing sampled in PWM off time
// - Current mode: window gated by comparator
// - Filter blanks comparator 2.5 us after on
// - On at window end, off at start/trip
// - Rate field picks window frequency
// - Window serves demag or zero-cross detection
// - Off-time field sets 5/10/15/30 us
// - Sensor mode fixes off-time 1.25 us
// - Mux sends PWM to low group, high group, both
// - Emergency forces high impedance asynchronously
// - Output-on bits preloaded, moved at commutation
// - Polarity and on bit set pin level
// - Direct access loads phase immediately
// - Polarity one means high is on
module motor_pwm_channel_manager
   import pwm_mgr_pkg::*;
(
   // Clock and reset
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   // APB slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic                           pready,
   output logic                           pslverr,
   output logic [31:0]                    prdata,
   // Motor side
   input  wire logic                      timer_a_pwm,
   input  wire logic                      current_sense_input,
   input  wire logic                      commutation_event,
   input  wire logic                      emergency_n,
   input  wire logic                      ratio_up_hw,
   input  wire logic                      ratio_down_hw,
   // Outputs
   output logic [pwm_mgr_pkg::NCH-1:0]    motor_channel_out,
   output logic [pwm_mgr_pkg::NCH-1:0]    motor_channel_oe,
   output logic                           zero_cross_sample
);
   // Control and data registers
   logic [7:0]     motor_ctrl_a, next_ctrl_a;
   logic [7:0]     motor_ctrl_b, next_ctrl_b;
   logic [NCH-1:0] phase_state_reg, next_phase_state;
   logic [NCH-1:0] phase_active, next_phase_active;
   logic [NCH-1:0] polarity_reg, next_polarity;
   logic [NCH-1:0] group_reg, next_group;
   logic [1:0]     off_time_sel, next_off_time;
   logic [3:0]     sample_rate_sel, next_sample_rate;
   logic [1:0]     motor_irq_status, next_irq_status;
   logic [7:0]     step_timer, next_step_timer;
   logic [7:0]     prev_zero_capture, next_prev_zero;
   logic [7:0]     cur_zero_capture, next_cur_zero;
   logic [7:0]     next_commutation_compare, next_compare;
   logic [7:0]     demag_value, next_demag;
   logic [3:0]     step_ratio, next_ratio;
   logic [31:0]    next_prdata;
   logic           next_pready;
   logic           next_pslverr;

   // Synchronisers and PWM state
   logic [2:0]       cmp_sync, tim_sync, com_sync, up_sync, dn_sync;
   logic             cmp, tim, com_lvl, up_prev, dn_prev;
   logic             next_cmp, next_tim, next_com, next_up, next_dn;
   logic             pwm, next_pwm;
   logic             window, window_prev;
   logic [CNT_W-1:0] blank_cnt, next_blank_cnt;
   logic [NCH-1:0]   next_out, next_oe;
   logic             next_zsample;
   logic             mode_oe, mode_swa;
   access_mode_t     mode;
   chan_cfg_t        cfg;

   window_gen u_window (
      .pclk          (pclk),
      .presetn       (presetn),
      .rate_sel      (sample_rate_sel),
      .off_sel       (off_time_sel),
      .sensor_select (motor_ctrl_a[CA_SR]),
      .window        (window)
   );

   assign mode_oe  = motor_ctrl_a[CA_OE];
   assign mode_swa = motor_ctrl_a[CA_SWA];
   assign mode     = access_mode_t'({mode_swa, mode_oe});
   assign cfg      = '{on: phase_active, pol: polarity_reg,
                       grp: group_reg};

   // Input filtering: change counts once stages 2 and 3 agree
   always_comb begin
      next_cmp = (cmp_sync[1] == cmp_sync[2]) ? cmp_sync[2] : cmp;
      next_tim = (tim_sync[1] == tim_sync[2]) ? tim_sync[2] : tim;
      next_com = (com_sync[1] == com_sync[2]) ? com_sync[2] : com_lvl;
      next_up  = (up_sync[1] == up_sync[2]) ? up_sync[2] : up_prev;
      next_dn  = (dn_sync[1] == dn_sync[2]) ? dn_sync[2] : dn_prev;
   end

   // Register file and APB
   always_comb begin
      logic wr;
      logic com_rise;
      wr                = psel && penable && pwrite;
      com_rise          = next_com && !com_lvl;
      next_ctrl_a       = motor_ctrl_a;
      next_ctrl_b       = motor_ctrl_b;
      next_phase_state  = phase_state_reg;
      next_phase_active = phase_active;
      next_polarity     = polarity_reg;
      next_group        = group_reg;
      next_off_time     = off_time_sel;
      next_sample_rate  = sample_rate_sel;
      next_irq_status   = motor_irq_status;
      next_step_timer   = step_timer;
      next_prev_zero    = prev_zero_capture;
      next_cur_zero     = cur_zero_capture;
      next_compare      = next_commutation_compare;
      next_demag        = demag_value;
      next_ratio        = step_ratio;
      next_prdata       = '0;
      next_pready       = psel && !penable;
      next_pslverr      = 1'b0;
      if (wr && pready) begin
         case (paddr)
            OFF_CTRL_A:   next_ctrl_a = pwdata[7:0];
            OFF_CTRL_B:   next_ctrl_b = pwdata[7:0];
            OFF_PHASE:    next_phase_state = pwdata[NCH-1:0];
            OFF_POLARITY: begin
               next_polarity = pwdata[NCH-1:0];
               next_off_time = pwdata[9:8];
            end
            OFF_PRESCALE: begin
               next_sample_rate = pwdata[3:0];
               next_group       = pwdata[13:8];
            end
            OFF_STATUS: begin
               if (mode == MODE_SWITCHED) begin
                  if (pwdata[ST_DOWN] && step_ratio != 4'h0)
                     next_ratio = step_ratio - 4'h1;
                  else if (pwdata[ST_UP] && step_ratio != 4'hf)
                     next_ratio = step_ratio + 4'h1;
               end else begin
                  next_irq_status = motor_irq_status & pwdata[1:0];
               end
            end
            OFF_TIMER:    if (!mode_oe) next_step_timer = pwdata[7:0];
            OFF_ZPREV:    if (!mode_oe) next_prev_zero = pwdata[7:0];
            OFF_ZCUR:     if (!mode_oe) next_cur_zero = pwdata[7:0];
            OFF_RATIO:    if (!mode_oe) next_ratio = pwdata[3:0];
            OFF_COMPARE:  if (mode != MODE_AUTO) next_compare = pwdata[7:0];
            OFF_DEMAG:    next_demag = pwdata[7:0];
            OFF_PWMSTAT:  ;
            default:      ;
         endcase
      end
      // Read data and error are set up on the setup edge
      if (next_pready && !pwrite) begin
         case (paddr)
            OFF_CTRL_A:   next_prdata = {24'h0, motor_ctrl_a};
            OFF_CTRL_B:   next_prdata = {24'h0, motor_ctrl_b};
            OFF_PHASE:    next_prdata = {26'h0, phase_state_reg};
            OFF_POLARITY: next_prdata = {22'h0, off_time_sel, 2'h0,
                                         polarity_reg};
            OFF_PRESCALE: next_prdata = {18'h0, group_reg, 4'h0,
                                         sample_rate_sel};
            OFF_STATUS:   next_prdata = {30'h0, motor_irq_status};
            OFF_TIMER:    next_prdata = {24'h0, step_timer};
            OFF_ZPREV:    next_prdata = {24'h0, prev_zero_capture};
            OFF_ZCUR:     next_prdata = {24'h0, cur_zero_capture};
            OFF_COMPARE:  next_prdata = {24'h0, next_commutation_compare};
            OFF_DEMAG:    next_prdata = {24'h0, demag_value};
            OFF_RATIO:    next_prdata = {28'h0, step_ratio};
            OFF_PWMSTAT:  next_prdata = {24'h0, window, cmp, pwm,
                                         phase_active[NCH-1:1] & 5'h0};
            default:      next_prdata = '0;
         endcase
      end
      if (next_pready)
         next_pslverr = (paddr > OFF_PWMSTAT) || (paddr[1:0] != 2'b00);
      // Hardware ratio updates in autoswitched mode; set wins over clear
      if (mode == MODE_AUTO) begin
         if (next_up && !up_prev && step_ratio != 4'hf) begin
            next_ratio         = step_ratio + 4'h1;
            next_irq_status[ST_UP] = 1'b1;
         end else if (next_dn && !dn_prev && step_ratio != 4'h0) begin
            next_ratio           = step_ratio - 4'h1;
            next_irq_status[ST_DOWN] = 1'b1;
         end
      end
      // Phase register load
      if (motor_ctrl_a[CA_DAC] && mode_oe)
         next_phase_active = next_phase_state;
      else if (com_rise)
         next_phase_active = phase_state_reg;
      if (!emergency_n) next_ctrl_a[CA_OE] = 1'b0;
   end

   // PWM manager and channel manager
   always_comb begin
      logic on_edge;
      logic cmp_seen;
      logic grp_pwm;
      grp_pwm        = 1'b0;
      on_edge        = window && !window_prev;
      next_blank_cnt = (blank_cnt != '0) ? blank_cnt - 1'b1 : '0;
      if (on_edge) next_blank_cnt = CNT_W'(BLANK_CYC);
      cmp_seen = cmp && !(motor_ctrl_b[CB_CFF] && blank_cnt != '0);
      if (!motor_ctrl_a[CA_VC]) begin
         next_pwm = tim && !cmp_seen;
      end else if (on_edge) begin
         next_pwm = 1'b1;
      end else if (!window || cmp_seen) begin
         next_pwm = 1'b0;
      end else begin
         next_pwm = pwm;
      end
      next_zsample = !pwm && !window;
      for (int i = 0; i < NCH; i++) begin
         grp_pwm = cfg.grp[i] ? motor_ctrl_b[CB_GRPH]
                              : motor_ctrl_b[CB_GRPL];
         if (!cfg.on[i]) next_out[i] = !cfg.pol[i];
         else next_out[i] = cfg.pol[i] ^ !(pwm || !grp_pwm);
         next_oe[i] = mode_oe;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motor_ctrl_a             <= '0;
         motor_ctrl_b             <= '0;
         phase_state_reg          <= '0;
         phase_active             <= '0;
         polarity_reg             <= '0;
         group_reg                <= '0;
         off_time_sel             <= '0;
         sample_rate_sel          <= '0;
         motor_irq_status         <= '0;
         step_timer               <= '0;
         prev_zero_capture        <= '0;
         cur_zero_capture         <= '0;
         next_commutation_compare <= '0;
         demag_value              <= '0;
         step_ratio               <= '0;
         prdata                   <= '0;
         pready                   <= 1'b0;
         pslverr                  <= 1'b0;
         cmp_sync <= '0; tim_sync <= '0; com_sync <= '0;
         up_sync <= '0; dn_sync <= '0;
         cmp <= 1'b0; tim <= 1'b0; com_lvl <= 1'b0;
         up_prev <= 1'b0; dn_prev <= 1'b0;
         pwm                      <= 1'b0;
         window_prev              <= 1'b1;
         blank_cnt                <= '0;
         zero_cross_sample        <= 1'b0;
      end else begin
         motor_ctrl_a             <= next_ctrl_a;
         motor_ctrl_b             <= next_ctrl_b;
         phase_state_reg          <= next_phase_state;
         phase_active             <= next_phase_active;
         polarity_reg             <= next_polarity;
         group_reg                <= next_group;
         off_time_sel             <= next_off_time;
         sample_rate_sel          <= next_sample_rate;
         motor_irq_status         <= next_irq_status;
         step_timer               <= next_step_timer;
         prev_zero_capture        <= next_prev_zero;
         cur_zero_capture         <= next_cur_zero;
         next_commutation_compare <= next_compare;
         demag_value              <= next_demag;
         step_ratio               <= next_ratio;
         prdata                   <= next_prdata;
         pready                   <= next_pready;
         pslverr                  <= next_pslverr;
         cmp_sync <= {cmp_sync[1:0], current_sense_input};
         tim_sync <= {tim_sync[1:0], timer_a_pwm};
         com_sync <= {com_sync[1:0], commutation_event};
         up_sync  <= {up_sync[1:0], ratio_up_hw};
         dn_sync  <= {dn_sync[1:0], ratio_down_hw};
         cmp <= next_cmp; tim <= next_tim; com_lvl <= next_com;
         up_prev <= next_up; dn_prev <= next_dn;
         pwm                      <= next_pwm;
         window_prev              <= window;
         blank_cnt                <= next_blank_cnt;
         zero_cross_sample        <= next_zsample;
      end
   end

   // Output stage; emergency drops the enables without a clock
   always_ff @(posedge pclk or negedge presetn or negedge emergency_n) begin
      if (!presetn) begin
         motor_channel_out <= '0;
         motor_channel_oe  <= '0;
      end else if (!emergency_n) begin
         motor_channel_out <= '0;
         motor_channel_oe  <= '0;
      end else begin
         motor_channel_out <= next_out;
         motor_channel_oe  <= next_oe;
      end
   end
endmodule

// ==== verilog/pwm_mgr_pkg.sv ====
package pwm_mgr_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL_A   = 8'h00;
   localparam logic [7:0] OFF_CTRL_B   = 8'h04;
   localparam logic [7:0] OFF_PHASE    = 8'h08;
   localparam logic [7:0] OFF_POLARITY = 8'h0c;
   localparam logic [7:0] OFF_PRESCALE = 8'h10;
   localparam logic [7:0] OFF_STATUS   = 8'h14;
   localparam logic [7:0] OFF_TIMER    = 8'h18;
   localparam logic [7:0] OFF_ZPREV    = 8'h1c;
   localparam logic [7:0] OFF_ZCUR     = 8'h20;
   localparam logic [7:0] OFF_COMPARE  = 8'h24;
   localparam logic [7:0] OFF_DEMAG    = 8'h28;
   localparam logic [7:0] OFF_RATIO    = 8'h2c;
   localparam logic [7:0] OFF_PWMSTAT  = 8'h30;

   // Control A bit positions
   localparam int CA_OE   = 0;
   localparam int CA_SWA  = 1;
   localparam int CA_VC   = 2;
   localparam int CA_DAC  = 3;
   localparam int CA_SR   = 4;
   // Control B bit positions
   localparam int CB_CFF  = 0;
   localparam int CB_GRPL = 1;
   localparam int CB_GRPH = 2;
   // Status bit positions
   localparam int ST_DOWN = 0;
   localparam int ST_UP   = 1;

   localparam int NCH = 6;

   // Timing
   localparam int    CLK_MHZ       = 100;
   localparam real   BLANK_US      = 2.5;
   localparam real   OT_SENSOR_US  = 1.25;
   localparam int    OFF_US [4]    = '{5, 10, 15, 30};
   localparam int    BLANK_CYC     = int'(BLANK_US * CLK_MHZ);
   localparam int    OT_SENSOR_CYC = int'(OT_SENSOR_US * CLK_MHZ);
   localparam int    CNT_W         = 16;

   // Window periods in ns, code 0 = 25.0 kHz down to 195 Hz
   localparam int WIN_NS [16] = '{40000, 50000, 55250, 64935, 80000,
      100000, 160000, 319489, 641026, 800000, 877193, 1040583,
      1280410, 1600000, 2564103, 5128205};

   typedef enum logic [1:0] {
      MODE_CONFIG, MODE_SWITCHED, MODE_ESTOP, MODE_AUTO
   } access_mode_t;

   typedef struct packed {
      logic [NCH-1:0] on;
      logic [NCH-1:0] pol;
      logic [NCH-1:0] grp;
   } chan_cfg_t;
endpackage

// ==== verilog/window_gen.sv ====
`timescale 1ns/10ps
module window_gen
   import pwm_mgr_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Configuration
   input  wire logic [3:0]  rate_sel,
   input  wire logic [1:0]  off_sel,
   input  wire logic        sensor_select,
   // Window is low during measurement
   output logic             window
);
   logic [CNT_W+2:0] cnt;
   logic [CNT_W+2:0] next_cnt;
   logic             next_window;
   logic [CNT_W+2:0] period;
   logic [CNT_W+2:0] off_len;

   always_comb begin
      period  = (CNT_W+3)'(WIN_NS[rate_sel] / (1000 / CLK_MHZ));
      if (sensor_select) begin
         off_len = (CNT_W+3)'(OT_SENSOR_CYC);
      end else begin
         off_len = (CNT_W+3)'(OFF_US[off_sel] * CLK_MHZ);
      end
      next_cnt = (cnt >= period - 1'b1) ? '0 : cnt + 1'b1;
      next_window = (next_cnt >= off_len);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt    <= '0;
         window <= 1'b1;
      end else begin
         cnt    <= next_cnt;
         window <= next_window;
      end
   end
endmodule
